// ==== src/pvtd_detector.sv ====
// Peak and valley tracking logic that switches one open-collector output.
// Assumes samples and the hysteresis code arrive synchronous to core_clk.
`default_nettype none
module pvtd_detector
  import pvtd_pkg::*;
#(
  parameter int unsigned SW = SAMPLE_W,
  parameter int unsigned HW = HYST_W
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic sample_valid,
  input wire logic [SW-1:0] sample,
  input wire logic [HW-1:0] switch_hysteresis,
  input wire logic polarity_reversed,
  output logic out_o,
  output logic out_oe,
  output logic test_mode,
  output logic rising,
  output logic [SW-1:0] held_extreme
);
  // The comparator zero-extends the hysteresis code, so it must be narrower than the sample.
  if (HW < 1 || HW >= SW)
  begin : g_bad_width
    $error("pvtd_detector: hysteresis width must be below sample width");
  end

  typedef struct packed {
    pvtd_state_t state;
    logic [SW-1:0] extreme;
    logic [HW-1:0] hyst;
    logic oe;
    logic test;
    logic dir;
  } pvtd_regs_t;

  pvtd_regs_t st_reg;
  pvtd_regs_t st_next;
  logic above;
  logic below;
  logic rose_by_hyst;
  logic fell_by_hyst;

  // The registered code is used, so the first edge after reset still sees the reset code.
  pvtd_compare #(.SW(SW), .HW(HW)) u_cmp (
    .sample(sample),
    .extreme(st_reg.extreme),
    .hyst(st_reg.hyst),
    .above(above),
    .below(below),
    .rose_by_hyst(rose_by_hyst),
    .fell_by_hyst(fell_by_hyst)
  );

  always_comb
  begin
    st_next = st_reg;
    st_next.hyst = switch_hysteresis;
    st_next.test = (st_reg.state == PVTD_TEST);
    // A reversed field wins over any sample, so samples that come while polarity_reversed is set are dropped.
    if (polarity_reversed)
    begin
      st_next.state = PVTD_TEST;
    end
    else if (sample_valid)
    begin
      unique case (st_reg.state)
        PVTD_TEST:
        begin
          // Leaving test restarts the search for a minimum with the driver off.
          st_next.state = PVTD_FIND_MIN;
          st_next.extreme = sample;
          st_next.oe = OUT_ON_RESET;
        end
        PVTD_FIND_MIN:
        begin
          // The output stays put until the first valley is confirmed.
          if (below)
          begin
            st_next.extreme = sample;
          end
          else if (rose_by_hyst)
          begin
            st_next.state = PVTD_RISING;
            st_next.extreme = sample;
          end
        end
        PVTD_RISING:
        begin
          if (above)
          begin
            st_next.extreme = sample;
          end
          else if (fell_by_hyst)
          begin
            st_next.state = PVTD_FALLING;
            st_next.oe = 1'b1;
            st_next.extreme = sample;
          end
        end
        PVTD_FALLING:
        begin
          if (below)
          begin
            st_next.extreme = sample;
          end
          else if (rose_by_hyst)
          begin
            st_next.state = PVTD_RISING;
            st_next.oe = 1'b0;
            st_next.extreme = sample;
          end
        end
      endcase
    end
    // Direction is registered together with the state so that the output comes from a flop.
    st_next.dir = (st_next.state == PVTD_RISING) || (st_next.state == PVTD_FIND_MIN);
    // Without a new sample only a reversed field moves the state, so the output holds at zero speed.
  end

  // Reset restarts the valley search with the driver off, so the pin reads high.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg.state <= PVTD_FIND_MIN;
      st_reg.extreme <= SW'(EXTREME_RESET);
      st_reg.hyst <= HW'(HYST_RESET);
      st_reg.oe <= OUT_ON_RESET;
      st_reg.test <= TEST_ON_RESET;
      st_reg.dir <= RISING_ON_RESET;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  // Open collector: the pin is only ever pulled low, so the enable alone carries the output.
  assign out_o = 1'b0;
  assign out_oe = st_reg.oe;
  assign test_mode = st_reg.test;
  assign rising = st_reg.dir;
  assign held_extreme = st_reg.extreme;

  // Reset and the first valley.
  reset_off_a: assert property (@(posedge core_clk) $rose(nrst) |-> !out_oe)
    else $error("output driven after reset");
  reset_held_a: assert property (@(posedge core_clk) $rose(nrst) |->
    held_extreme == SW'(EXTREME_RESET) && !test_mode && rising)
    else $error("held state not cleared by reset");
  no_early_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_reg.state == PVTD_FIND_MIN) |=> !out_oe || $past(st_reg.state) != PVTD_FIND_MIN)
    else $error("output switched before first minimum");
  first_min_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && sample_valid && !polarity_reversed && st_reg.state == PVTD_FIND_MIN && !below && rose_by_hyst
    |=> rising && !out_oe && held_extreme == $past(sample))
    else $error("first minimum not confirmed");
  min_track_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && sample_valid && !polarity_reversed && st_reg.state == PVTD_FIND_MIN && below
    |=> held_extreme == $past(sample) && !out_oe)
    else $error("valley search did not follow the field");

  // Switching points and tracking.
  turn_on_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && sample_valid && !polarity_reversed && st_reg.state == PVTD_RISING && !above && fell_by_hyst
    |=> out_oe && held_extreme == $past(sample))
    else $error("output did not turn on after peak");
  turn_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && sample_valid && !polarity_reversed && st_reg.state == PVTD_FALLING && !below && rose_by_hyst
    |=> !out_oe && held_extreme == $past(sample))
    else $error("output did not turn off after valley");
  rise_cause_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(out_oe) |-> $past(st_reg.state) == PVTD_RISING && st_reg.state == PVTD_FALLING)
    else $error("output turned on away from a peak");
  fall_cause_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(out_oe) |-> st_reg.state == PVTD_RISING || st_reg.state == PVTD_FIND_MIN)
    else $error("output turned off away from a valley");
  track_peak_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && sample_valid && !polarity_reversed && st_reg.state == PVTD_RISING && above
    |=> held_extreme == $past(sample) && !$changed(out_oe))
    else $error("peak not tracked");
  track_valley_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && sample_valid && !polarity_reversed && st_reg.state == PVTD_FALLING && below
    |=> held_extreme == $past(sample) && !$changed(out_oe))
    else $error("valley not tracked");
  hyst_follow_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en |=> st_reg.hyst == $past(switch_hysteresis))
    else $error("hysteresis not taken from its code");

  // Test state, idle and clock enable.
  test_entry_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && polarity_reversed ##1 clk_en |=> test_mode)
    else $error("test mode not entered");
  test_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    polarity_reversed && st_reg.state == PVTD_TEST |=> $stable(out_oe) && $stable(held_extreme))
    else $error("tracking moved in test state");
  test_exit_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && sample_valid && !polarity_reversed && st_reg.state == PVTD_TEST
    |=> !out_oe && rising && held_extreme == $past(sample))
    else $error("test exit did not restart the minimum search");
  hold_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !sample_valid && !polarity_reversed |=> $stable(out_oe) && $stable(held_extreme))
    else $error("state moved without a sample");
  enable_freeze_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !clk_en |=> $stable(st_reg))
    else $error("state moved while clock enable was low");
endmodule : pvtd_detector
`default_nettype wire

// ==== src/pvtd_pkg.sv ====
// Package for the peak and valley tooth detector: widths, reset values and state encodings.
// Assumes a single core clock domain; no registers are reached by software.
`default_nettype none
package pvtd_pkg;
  localparam int unsigned SAMPLE_W = 10;
  localparam int unsigned HYST_W = 4;
  localparam logic [SAMPLE_W-1:0] EXTREME_RESET = 10'h000;
  localparam logic OUT_ON_RESET = 1'b0;
  localparam logic [HYST_W-1:0] HYST_RESET = 4'h0;
  localparam logic TEST_ON_RESET = 1'b0;
  localparam logic RISING_ON_RESET = 1'b1;
  // Gray-coded tracking states along start, rising, falling, with test last.
  typedef enum logic [1:0] {
    PVTD_FIND_MIN = 2'h0,
    PVTD_RISING = 2'h1,
    PVTD_FALLING = 2'h3,
    PVTD_TEST = 2'h2
  } pvtd_state_t;
endpackage : pvtd_pkg
`default_nettype wire

// ==== src/pvtd_compare.sv ====
// Comparator for the tracking logic: sample against held extreme and hysteresis.
// Purely combinational; widths come from the parent.
`default_nettype none
module pvtd_compare
  import pvtd_pkg::*;
#(
  parameter int unsigned SW = SAMPLE_W,
  parameter int unsigned HW = HYST_W
)
(
  input wire logic [SW-1:0] sample,
  input wire logic [SW-1:0] extreme,
  input wire logic [HW-1:0] hyst,
  output logic above,
  output logic below,
  output logic rose_by_hyst,
  output logic fell_by_hyst
);
  logic [SW:0] ext_plus;
  logic [SW:0] smp_plus;
  always_comb
  begin
    ext_plus = {1'b0, extreme} + {{(SW+1-HW){1'b0}}, hyst};
    smp_plus = {1'b0, sample} + {{(SW+1-HW){1'b0}}, hyst};
    above = sample > extreme;
    below = sample < extreme;
    rose_by_hyst = {1'b0, sample} >= ext_plus;
    fell_by_hyst = smp_plus <= {1'b0, extreme};
  end
endmodule : pvtd_compare
`default_nettype wire

// ==== dv/pvtd_reader.sv ====
// Controller model that reads the open-collector output pin.
// Assumes a pull-up holds the pin high whenever the driver is off.
`default_nettype none
module pvtd_reader
(
  input wire logic out_o,
  input wire logic out_oe,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin = out_oe ? out_o : 1'b1;
endmodule : pvtd_reader
`default_nettype wire

// ==== dv/pvtd_detector_bench.sv ====
// Self-checking bench for the peak and valley tooth detector.
// Assumes hysteresis code 4 and samples given on falling edges.
`default_nettype none
module pvtd_detector_bench import pvtd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic sample_valid = 1'b0;
  logic [SAMPLE_W-1:0] sample = 10'h000;
  logic [HYST_W-1:0] hyst = 4'h4;
  logic polarity_reversed = 1'b0;
  logic out_o, out_oe, test_mode, rising, pin;
  logic [SAMPLE_W-1:0] held;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  pvtd_detector u_pvtd_detector (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .sample_valid(sample_valid), .sample(sample), .switch_hysteresis(hyst),
    .polarity_reversed(polarity_reversed), .out_o(out_o), .out_oe(out_oe),
    .test_mode(test_mode), .rising(rising), .held_extreme(held));
  pvtd_reader u_pvtd_reader (.out_o(out_o), .out_oe(out_oe), .pin(pin));
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s exp %b got %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_val(input string what, input logic [SAMPLE_W-1:0] exp, input logic [SAMPLE_W-1:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask : chk_val
  // One idle cycle follows each sample, so the strobe is never set twice in one step.
  task automatic send(input logic [SAMPLE_W-1:0] v);
    sample = v;
    sample_valid = 1'b1;
    @(negedge core_clk);
    sample_valid = 1'b0;
    @(negedge core_clk);
  endtask : send
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // Peak then a fall of one short of the hysteresis, then exactly the hysteresis.
  task automatic t_peak;
    send(10'h100);
    chk_bit("pin", 1'b1, pin);
    chk_bit("rising", 1'b1, rising);
    send(10'h200);
    chk_val("held", 10'h200, held);
    send(10'h1FD);
    chk_bit("pin", 1'b1, pin);
    send(10'h1FC);
    chk_bit("pin", 1'b0, pin);
    chk_bit("out_o", 1'b0, out_o);
    chk_val("held", 10'h1FC, held);
    chk_bit("rising", 1'b0, rising);
  endtask : t_peak
  // A frozen clock enable and a long idle spell must not move the output.
  task automatic t_hold;
    clk_en = 1'b0;
    send(10'h100);
    clk_en = 1'b1;
    chk_val("held", 10'h1FC, held);
    repeat (100) @(negedge core_clk);
    chk_bit("pin", 1'b0, pin);
    chk_val("held", 10'h1FC, held);
  endtask : t_hold
  // Valley then a rise of one short of the hysteresis, then exactly the hysteresis.
  task automatic t_valley;
    send(10'h150);
    send(10'h153);
    chk_bit("pin", 1'b0, pin);
    send(10'h154);
    chk_bit("pin", 1'b1, pin);
    chk_val("held", 10'h154, held);
  endtask : t_valley
  task automatic t_test;
    polarity_reversed = 1'b1;
    send(10'h000);
    @(negedge core_clk);
    chk_bit("test_mode", 1'b1, test_mode);
    chk_val("held", 10'h154, held);
    polarity_reversed = 1'b0;
    repeat (2) @(negedge core_clk);
    chk_bit("test_mode", 1'b1, test_mode);
    send(10'h120);
    chk_bit("test_mode", 1'b0, test_mode);
    chk_val("held", 10'h120, held);
    chk_bit("pin", 1'b1, pin);
  endtask : t_test
  // A valley search that follows the field, a switch on, then a reset in mid-run.
  task automatic t_reset;
    send(10'h110);
    chk_val("held", 10'h110, held);
    chk_bit("pin", 1'b1, pin);
    send(10'h120);
    send(10'h11C);
    chk_bit("pin", 1'b0, pin);
    nrst = 1'b0;
    @(negedge core_clk);
    chk_bit("pin", 1'b1, pin);
    chk_val("held", EXTREME_RESET, held);
    nrst = 1'b1;
    @(negedge core_clk);
    send(10'h003);
    chk_bit("pin", 1'b1, pin);
    chk_val("held", EXTREME_RESET, held);
  endtask : t_reset
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  initial
  begin
    repeat (10) @(negedge core_clk);
    chk_bit("pin", 1'b1, pin);
    nrst = 1'b1;
    @(negedge core_clk);
    chk_val("held", EXTREME_RESET, held);
    t_peak();
    t_hold();
    t_valley();
    t_test();
    t_reset();
    final_report();
  end
endmodule : pvtd_detector_bench
`default_nettype wire
